// file: eeprom_ctrl_pkg.sv
package eeprom_ctrl_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [2:0] IDX_CLOCK_DIVIDER = 3'h0;
    localparam logic [2:0] IDX_FACTORY_TEST_A = 3'h1;
    localparam logic [2:0] IDX_FACTORY_TEST_B = 3'h2;
    localparam logic [2:0] IDX_INTERRUPT_CONFIG = 3'h3;
    localparam logic [2:0] IDX_PROTECTION_CONFIG = 3'h4;
    localparam logic [2:0] IDX_STATUS_REGISTER = 3'h5;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 3;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DIV_LOADED_BIT = 7;
    localparam int DIV_PRESCALE_BIT = 6;
    localparam int DIV_VALUE_W = 6;
    localparam int IRQ_BUF_EMPTY_BIT = 7;
    localparam int IRQ_ALL_DONE_BIT = 6;
    localparam int PROT_OPEN_BIT = 7;
    localparam int PROT_USER_HI = 6;
    localparam int PROT_USER_LO = 4;
    localparam int PROT_RANGE_DIS_BIT = 3;
    localparam int PROT_SIZE_W = 3;
    localparam int STAT_BUF_EMPTY_BIT = 7;
    localparam int STAT_ALL_DONE_BIT = 6;
    localparam int STAT_VIOL_BIT = 5;

    // ************************************************************
    // Array geometry and timing
    // ************************************************************
    localparam int ARRAY_ADDR_W = 11;
    localparam int SECTOR_UNIT_LSB = 6;
    localparam logic [4:0] TOP_UNIT = 5'h1F;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic BUF_EMPTY_RESET = 1'b1;
    localparam logic ALL_DONE_RESET = 1'b1;

endpackage

// file: eeprom_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_timebase #(
    parameter int DIV_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic prescale_i,
    input wire logic [DIV_W-1:0] divide_i,
    output logic tick_o
);
    typedef struct packed {
        logic [2:0] pre;
        logic [DIV_W-1:0] cnt;
        logic tick;
    } tb_state_t;

    tb_state_t st_r;
    tb_state_t st_nxt;
    logic pre_done;

    // ************************************************************
    // Prescaler then divider, ratio up to 8 x 64
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        pre_done = !prescale_i || (st_r.pre == eeprom_ctrl_pkg::PRESCALE_LAST);
        if (!run_i)
        begin
            st_nxt.pre = '0;
            st_nxt.cnt = '0;
        end
        else
        begin
            st_nxt.pre = pre_done ? 3'h0 : 3'(st_r.pre + 3'h1);
            if (pre_done)
            begin
                if (st_r.cnt == divide_i)
                begin
                    st_nxt.cnt = '0;
                    st_nxt.tick = 1'b1;
                end
                else
                begin
                    st_nxt.cnt = DIV_W'(st_r.cnt + 1'b1);
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick_o = st_r.tick;
endmodule
`default_nettype wire

// file: eeprom_protect_check.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_protect_check #(
    parameter int AW = 11
) (
    input wire logic [AW-1:0] addr_i,
    input wire logic global_open_i,
    input wire logic range_disable_i,
    input wire logic [2:0] size_code_i,
    output logic addr_protected_o,
    output logic mass_allowed_o
);
    logic [4:0] low_unit;
    logic in_top;

    // ************************************************************
    // Top sector from 64-byte unit (31 - code) up to 0x07FF
    // ************************************************************
    always_comb
    begin
        low_unit = eeprom_ctrl_pkg::TOP_UNIT - {2'b00, size_code_i};
        in_top = (addr_i[AW-1:eeprom_ctrl_pkg::SECTOR_UNIT_LSB] >= low_unit);
        addr_protected_o = !global_open_i || (!range_disable_i && in_top);
        mass_allowed_o = global_open_i && range_disable_i;
    end
endmodule
`default_nettype wire

// file: eeprom_timing_irq_protect_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_timing_irq_protect_ctrl #(
    parameter int DIV_W = 6,
    parameter int AW = 11
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Protection byte from the array, sampled during reset
    input wire logic [7:0] prot_byte_i,
    // Sequencer side
    input wire logic cmd_req_i,
    input wire logic cmd_mass_i,
    input wire logic [AW-1:0] cmd_addr_i,
    input wire logic buf_empty_set_i,
    input wire logic all_done_set_i,
    output logic cmd_accept_o,
    output logic cmd_refuse_o,
    output logic timebase_tick_o,
    output logic irq_o
);

    // ************************************************************
    // Block state
    // ************************************************************
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic div_loaded;
        logic prescale_by_eight;
        logic [DIV_W-1:0] divide_value;
        logic buffer_empty_irq_enable;
        logic all_done_irq_enable;
        logic global_open;
        logic [2:0] user_persistent_flags;
        logic range_protect_disable;
        logic [2:0] protected_size_code;
        logic buffer_empty_flag;
        logic all_done_flag;
        logic protection_violation_flag;
        logic accept;
        logic refuse;
    } ctrl_state_t;

    ctrl_state_t st_r;
    ctrl_state_t st_nxt;

    logic [eeprom_ctrl_pkg::IDX_W-1:0] reg_idx;
    logic idx_mapped;
    logic req;
    logic wr_fire;
    logic wr_lane;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic addr_protected;
    logic mass_allowed;
    logic buf_clear;
    logic viol_clear;

    // ************************************************************
    // Bus decode
    // ************************************************************
    // Only the low byte lane carries register data
    assign req = wb_cyc_i && wb_stb_i;
    assign reg_idx = wb_adr_i[eeprom_ctrl_pkg::ADDR_LSB +: eeprom_ctrl_pkg::IDX_W];
    assign idx_mapped = (wb_adr_i[eeprom_ctrl_pkg::ADDR_LSB-1:0] == 2'b00);
    // Writes without the low lane are acked but change nothing
    assign wr_lane = wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    // Write lands at the edge where ack is seen high
    assign wr_fire = req && wb_we_i && st_r.ack && wr_lane && idx_mapped;

    // ************************************************************
    // Timebase and protection compare
    // ************************************************************
    // Divider stays idle until software has loaded it once
    eeprom_timebase #(
        .DIV_W(DIV_W)
    ) u_timebase (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(st_r.div_loaded),
        .prescale_i(st_r.prescale_by_eight),
        .divide_i(st_r.divide_value),
        .tick_o(timebase_tick_o)
    );

    // Pure compare; decision is registered below
    eeprom_protect_check #(
        .AW(AW)
    ) u_protect (
        .addr_i(cmd_addr_i),
        .global_open_i(st_r.global_open),
        .range_disable_i(st_r.range_protect_disable),
        .size_code_i(st_r.protected_size_code),
        .addr_protected_o(addr_protected),
        .mass_allowed_o(mass_allowed)
    );

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    // Unmapped and factory indices answer zero
    always_comb
    begin
        rd_byte = eeprom_ctrl_pkg::BYTE_ZERO;
        if (idx_mapped)
        begin
            case (reg_idx)
                eeprom_ctrl_pkg::IDX_CLOCK_DIVIDER:
                begin
                    rd_byte[eeprom_ctrl_pkg::DIV_LOADED_BIT] = st_r.div_loaded;
                    rd_byte[eeprom_ctrl_pkg::DIV_PRESCALE_BIT] = st_r.prescale_by_eight;
                    rd_byte[DIV_W-1:0] = st_r.divide_value;
                end
                eeprom_ctrl_pkg::IDX_FACTORY_TEST_A:
                begin
                    rd_byte = eeprom_ctrl_pkg::BYTE_ZERO;
                end
                eeprom_ctrl_pkg::IDX_FACTORY_TEST_B:
                begin
                    rd_byte = eeprom_ctrl_pkg::BYTE_ZERO;
                end
                eeprom_ctrl_pkg::IDX_INTERRUPT_CONFIG:
                begin
                    rd_byte[eeprom_ctrl_pkg::IRQ_BUF_EMPTY_BIT] = st_r.buffer_empty_irq_enable;
                    rd_byte[eeprom_ctrl_pkg::IRQ_ALL_DONE_BIT] = st_r.all_done_irq_enable;
                end
                eeprom_ctrl_pkg::IDX_PROTECTION_CONFIG:
                begin
                    rd_byte[eeprom_ctrl_pkg::PROT_OPEN_BIT] = st_r.global_open;
                    rd_byte[eeprom_ctrl_pkg::PROT_USER_HI:eeprom_ctrl_pkg::PROT_USER_LO] =
                        st_r.user_persistent_flags;
                    rd_byte[eeprom_ctrl_pkg::PROT_RANGE_DIS_BIT] = st_r.range_protect_disable;
                    rd_byte[eeprom_ctrl_pkg::PROT_SIZE_W-1:0] = st_r.protected_size_code;
                end
                eeprom_ctrl_pkg::IDX_STATUS_REGISTER:
                begin
                    // Status bits 4:0 are not implemented and read zero
                    rd_byte[eeprom_ctrl_pkg::STAT_BUF_EMPTY_BIT] = st_r.buffer_empty_flag;
                    rd_byte[eeprom_ctrl_pkg::STAT_ALL_DONE_BIT] = st_r.all_done_flag;
                    rd_byte[eeprom_ctrl_pkg::STAT_VIOL_BIT] = st_r.protection_violation_flag;
                end
                default:
                begin
                    rd_byte = eeprom_ctrl_pkg::BYTE_ZERO;
                end
            endcase
        end
    end

    // ************************************************************
    // Software clears of status flags
    // ************************************************************
    // Write-one-to-clear; writing zero leaves the flag alone
    always_comb
    begin
        buf_clear = 1'b0;
        viol_clear = 1'b0;
        if (wr_fire && (reg_idx == eeprom_ctrl_pkg::IDX_STATUS_REGISTER))
        begin
            buf_clear = wbyte[eeprom_ctrl_pkg::STAT_BUF_EMPTY_BIT];
            viol_clear = wbyte[eeprom_ctrl_pkg::STAT_VIOL_BIT];
        end
    end

    // A clear that loses to a same-cycle set is no clear at all
    logic buf_cleared;
    assign buf_cleared = buf_clear && !buf_empty_set_i;

    // ************************************************************
    // Launch decision
    // ************************************************************
    // Split out so the flag update below reads as set-wins-over-clear
    logic cmd_blocked;
    logic cmd_violates;
    logic viol_raise;

    // A standing violation refuses every launch and leaves the flag as it is
    assign cmd_blocked = st_r.protection_violation_flag;
    // Mass erase has its own gate; single targets use the address compare
    assign cmd_violates = cmd_mass_i ? !mass_allowed : addr_protected;
    // Only a fresh violation sets the flag
    assign viol_raise = cmd_req_i && !cmd_blocked && cmd_violates;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        // Answers are one-cycle pulses unless raised again below
        st_nxt.accept = 1'b0;
        st_nxt.refuse = 1'b0;

        // Ack for one cycle, then drop even if strobe is still high
        st_nxt.ack = req && !st_r.ack;
        // Read data is caught with the request and stands through the ack cycle
        if (req && !st_r.ack)
            st_nxt.rdata = rd_byte;

        // Register writes
        if (wr_fire)
        begin
            case (reg_idx)
                eeprom_ctrl_pkg::IDX_CLOCK_DIVIDER:
                begin
                    // Write-once: later writes cannot retime a running erase
                    if (!st_r.div_loaded)
                    begin
                        st_nxt.div_loaded = 1'b1;
                        st_nxt.prescale_by_eight = wbyte[eeprom_ctrl_pkg::DIV_PRESCALE_BIT];
                        st_nxt.divide_value = wbyte[DIV_W-1:0];
                    end
                end
                eeprom_ctrl_pkg::IDX_INTERRUPT_CONFIG:
                begin
                    st_nxt.buffer_empty_irq_enable = wbyte[eeprom_ctrl_pkg::IRQ_BUF_EMPTY_BIT];
                    st_nxt.all_done_irq_enable = wbyte[eeprom_ctrl_pkg::IRQ_ALL_DONE_BIT];
                end
                eeprom_ctrl_pkg::IDX_PROTECTION_CONFIG:
                begin
                    // Protection can only be tightened until the next reset
                    st_nxt.global_open = st_r.global_open &&
                        wbyte[eeprom_ctrl_pkg::PROT_OPEN_BIT];
                    st_nxt.range_protect_disable = st_r.range_protect_disable &&
                        wbyte[eeprom_ctrl_pkg::PROT_RANGE_DIS_BIT];
                    // Size uses the pre-write disable bit, so one write may do both
                    if (st_r.range_protect_disable)
                        st_nxt.protected_size_code = wbyte[eeprom_ctrl_pkg::PROT_SIZE_W-1:0];
                end
                default:
                begin
                    // Factory and unmapped indices swallow writes
                    st_nxt.rdata = st_nxt.rdata;
                end
            endcase
        end

        // Buffer-empty flag: hardware set wins over software clear
        if (buf_empty_set_i)
            st_nxt.buffer_empty_flag = 1'b1;
        else if (buf_clear)
            st_nxt.buffer_empty_flag = 1'b0;

        // All-done flag follows the buffer-empty clear
        if (all_done_set_i)
            st_nxt.all_done_flag = 1'b1;
        else if (buf_cleared)
            st_nxt.all_done_flag = 1'b0;

        // Command launch check
        if (cmd_req_i)
        begin
            if (cmd_blocked)
            begin
                st_nxt.refuse = 1'b1;
            end
            else if (cmd_violates)
            begin
                st_nxt.refuse = 1'b1;
                st_nxt.protection_violation_flag = 1'b1;
            end
            else
            begin
                st_nxt.accept = 1'b1;
            end
        end

        // Clear applies only when no violation is raised this cycle
        if (viol_clear && !viol_raise)
            st_nxt.protection_violation_flag = 1'b0;
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Synchronous reset, so the array byte may be captured here
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            // Buffer starts empty and nothing is pending
            st_r.buffer_empty_flag <= eeprom_ctrl_pkg::BUF_EMPTY_RESET;
            st_r.all_done_flag <= eeprom_ctrl_pkg::ALL_DONE_RESET;
            // Protection comes from the array byte, sampled on every reset edge
            st_r.global_open <= prot_byte_i[eeprom_ctrl_pkg::PROT_OPEN_BIT];
            st_r.user_persistent_flags <=
                prot_byte_i[eeprom_ctrl_pkg::PROT_USER_HI:eeprom_ctrl_pkg::PROT_USER_LO];
            st_r.range_protect_disable <= prot_byte_i[eeprom_ctrl_pkg::PROT_RANGE_DIS_BIT];
            st_r.protected_size_code <= prot_byte_i[eeprom_ctrl_pkg::PROT_SIZE_W-1:0];
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_ack_o = st_r.ack;
    // Upper byte lanes are not implemented and read zero
    assign wb_dat_o = {24'h000000, st_r.rdata};
    // Command answers come straight from flops
    assign cmd_accept_o = st_r.accept;
    assign cmd_refuse_o = st_r.refuse;

    // ************************************************************
    // Interrupt request
    // ************************************************************
    // One source per flag and enable pair; buffer-empty is bit 0
    localparam int IRQ_SRC_N = 2;
    logic [IRQ_SRC_N-1:0] irq_flag;
    logic [IRQ_SRC_N-1:0] irq_enable;
    logic [IRQ_SRC_N-1:0] irq_hit;

    // Adding a source means widening the count and both vectors
    assign irq_flag = {st_r.all_done_flag, st_r.buffer_empty_flag};
    assign irq_enable = {st_r.all_done_irq_enable, st_r.buffer_empty_irq_enable};

    // Level per source with no latch, so a cleared flag drops the request at once
    generate
        for (genvar s = 0; s < IRQ_SRC_N; s++)
        begin : g_irq_src
            assign irq_hit[s] = irq_flag[s] && irq_enable[s];
        end
    endgenerate

    assign irq_o = |irq_hit;

endmodule
`default_nettype wire

// file: eeprom_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_ctrl_props #(
    parameter int DIV_W = 6,
    parameter int AW = 11
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cmd_req_i,
    input wire logic cmd_accept_o,
    input wire logic cmd_refuse_o,
    input wire logic timebase_tick_o,
    input wire logic irq_o
);
    // Shadow of the divider-loaded state, set by the first acked low-lane write to address 0x00
    logic loaded_r;
    wire rd_ack = wb_ack_o && !wb_we_i;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            loaded_r <= 1'b0;
        else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
            loaded_r <= 1'b1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    idle_no_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    factory_zero_a: assert property (rd_ack && (wb_adr_i == 8'h04 || wb_adr_i == 8'h08) |-> wb_dat_o == 32'h0)
        else $error("factory register not zero");
    config_low_zero_a: assert property (rd_ack && wb_adr_i == 8'h0C |-> wb_dat_o[5:0] == 6'h00)
        else $error("config low bits not zero");
    div_loaded_a: assert property (rd_ack && wb_adr_i == 8'h00 |-> wb_dat_o[7] == loaded_r)
        else $error("divider loaded bit wrong");
    tick_idle_a: assert property (!loaded_r |-> !timebase_tick_o)
        else $error("tick before divider loaded");
    cmd_answer_a: assert property (cmd_req_i |=> cmd_accept_o != cmd_refuse_o)
        else $error("request without single answer");
    cmd_quiet_a: assert property (!cmd_req_i |=> !cmd_accept_o && !cmd_refuse_o) else $error("answer without request");
    viol_hold_a: assert property (cmd_refuse_o && cmd_req_i && !(wb_ack_o && wb_we_i)
        && !$past(wb_ack_o && wb_we_i) |=> cmd_refuse_o) else $error("launch while violation set");
    // Reset clears enables, so nothing may be raised right after it
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0) !rst_n_i |=> !irq_o && !timebase_tick_o)
        else $error("output active after reset");

    cover property (wb_ack_o && wb_we_i);
    cover property (cmd_refuse_o);
    cover property (cmd_accept_o);
    cover property (irq_o);
endmodule

bind eeprom_timing_irq_protect_ctrl eeprom_ctrl_props #(.DIV_W(DIV_W), .AW(AW)) eeprom_ctrl_props_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_req_i(cmd_req_i),
    .cmd_accept_o(cmd_accept_o), .cmd_refuse_o(cmd_refuse_o), .timebase_tick_o(timebase_tick_o), .irq_o(irq_o));
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t: got %0h want %0h", $time, (a), (b)); end end
module testbench;
    logic clk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_o, tick_o;
    logic cmd_req_i = 0, cmd_mass_i = 0, cmd_accept_o, cmd_refuse_o, buf_empty_set_i = 0, all_done_set_i = 0;
    logic [7:0] wb_adr_i = 8'h00, prot_byte_i = 8'h00, prot, dv, w;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [10:0] cmd_addr_i = 11'h0;
    logic viol;
    int bad_count = 0, checks = 0, seed = 5871;

    always #5 clk_i = ~clk_i;

    eeprom_timing_irq_protect_ctrl eeprom_timing_irq_protect_ctrl_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .prot_byte_i(prot_byte_i), .cmd_req_i(cmd_req_i), .cmd_mass_i(cmd_mass_i), .cmd_addr_i(cmd_addr_i),
        .buf_empty_set_i(buf_empty_set_i), .all_done_set_i(all_done_set_i), .cmd_accept_o(cmd_accept_o),
        .cmd_refuse_o(cmd_refuse_o), .timebase_tick_o(tick_o), .irq_o(irq_o));

    // ********************************************************
    // Bus and stimulus tasks
    // ********************************************************
    // Request held until ack is sampled at a rising edge, released at that edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        `CHK(n < 20, 1'b1)
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // Callers look at outputs only once the write has settled
        @(negedge clk_i);
    endtask

    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 8'h00);
        `CHK(rd, exp)
    endtask

    task automatic do_reset(input logic [7:0] p);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        prot_byte_i <= p;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        prot = p;
        viol = 1'b0;
    endtask

    // Expected refusal from the current protection model
    function automatic logic is_prot(input logic mass, input logic [10:0] a);
        if (mass)
            return !(prot[7] && prot[3]);
        return !prot[7] || (!prot[3] && a[10:6] >= 5'd31 - prot[2:0]);
    endfunction

    task automatic cmd(input logic mass, input logic [10:0] a);
        logic r;
        r = viol || is_prot(mass, a);
        @(posedge clk_i);
        cmd_req_i <= 1'b1;
        cmd_mass_i <= mass;
        cmd_addr_i <= a;
        // A refused request is repeated at once and must be refused again
        @(posedge clk_i);
        cmd_req_i <= r;
        @(negedge clk_i);
        `CHK({cmd_refuse_o, cmd_accept_o}, {r, !r})
        @(posedge clk_i);
        cmd_req_i <= 1'b0;
        @(negedge clk_i);
        `CHK({cmd_refuse_o, cmd_accept_o}, {r, 1'b0})
        viol = r;
        wb(1'b0, 8'h14, 8'h00);
        `CHK(rd[5], viol)
    endtask

    task automatic pulse(input logic be);
        @(posedge clk_i);
        buf_empty_set_i <= be;
        all_done_set_i <= !be;
        @(posedge clk_i);
        buf_empty_set_i <= 1'b0;
        all_done_set_i <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic stop_test();
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        int n;
        do_reset(8'h00);
        // Interrupt enables against both flags, which start set
        rchk(8'h0C, 32'h0);
        wb(1'b1, 8'h0C, 8'hFF);
        rchk(8'h0C, 32'hC0);
        wb(1'b1, 8'h0C, 8'h80);
        `CHK(irq_o, 1'b1)
        wb(1'b1, 8'h0C, 8'h40);
        `CHK(irq_o, 1'b1)
        wb(1'b1, 8'h14, 8'h80);
        rchk(8'h14, 32'h0);
        `CHK(irq_o, 1'b0)
        pulse(1'b0);
        `CHK(irq_o, 1'b1)
        wb(1'b1, 8'h0C, 8'h80);
        `CHK(irq_o, 1'b0)
        pulse(1'b1);
        `CHK(irq_o, 1'b1)
        wb(1'b1, 8'h0C, 8'h00);
        `CHK(irq_o, 1'b0)
        for (int i = 0; i < 6; i++)
        begin
            do_reset(8'($random(seed)));
            dv = (i == 0) ? 8'h7F : (i == 1) ? 8'h00 : 8'($random(seed));
            rchk(8'h00, 32'h0);
            wb(1'b1, 8'h00, dv);
            rchk(8'h00, {24'h0, 1'b1, dv[6:0]});
            wb(1'b1, 8'h00, ~dv);
            rchk(8'h00, {24'h0, 1'b1, dv[6:0]});
            // Tick spacing, including the 512 extreme
            n = 0;
            do
            begin
                @(negedge clk_i);
                n++;
            end
            while (tick_o !== 1'b1 && n < 1100);
            n = 0;
            do
            begin
                @(negedge clk_i);
                n++;
            end
            while (tick_o !== 1'b1 && n < 600);
            `CHK(n, (dv[6] ? 8 : 1) * (dv[5:0] + 1))
            rchk(8'h10, {24'h0, prot});
            wb(1'b1, 8'h04, 8'hFF);
            rchk(8'h04, 32'h0);
            wb(1'b1, 8'h08, 8'hFF);
            rchk(8'h08, 32'h0);
            rchk(8'h18, 32'h0);
            // Protection write: open and disable only drop, size frozen once disable is 0
            w = 8'($random(seed));
            wb(1'b1, 8'h10, w);
            prot = {prot[7] & w[7], prot[6:4], prot[3] & w[3], prot[3] ? w[2:0] : prot[2:0]};
            rchk(8'h10, {24'h0, prot});
            cmd(1'b0, 11'h7FD);
            repeat (6)
            begin
                // Addresses straddle the lower edge of the protected sector
                cmd(($random(seed) & 3) == 0, {5'd31 - prot[2:0] - 5'($random(seed) & 1), 6'($random(seed))});
                if (viol && ($random(seed) & 1))
                begin
                    wb(1'b1, 8'h14, 8'h20);
                    viol = 1'b0;
                end
            end
        end
        stop_test();
    end

    // A hang counts as a failure
    initial
    begin
        #400_000;
        bad_count++;
        stop_test();
    end
endmodule
`undef CHK
`default_nettype wire
